//--- design/bslk_pkg.sv
// constants, states and lockout causes of the burner lockout sequencer
package bslk_pkg;
    // ------------------------------------------------------------
    // clock and time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned TICK_HZ      = 1000;            // one tick per millisecond
    localparam int unsigned TICK_CYC     = CLK_HZ / TICK_HZ;
    localparam int          MS_W         = 17;
    // ------------------------------------------------------------
    // phase times in milliseconds
    // ------------------------------------------------------------
    localparam logic [16:0] AIR_WAIT_MS  = 17'd60000;       // air switch must close
    localparam logic [16:0] PURGE_MS     = 17'd24000;       // purge_interval
    localparam logic [16:0] PREIGN_MS    = 17'd3000;
    localparam logic [16:0] SAFETY_MS    = 17'd3000;        // flame_safety_interval
    localparam logic [16:0] FAN_PULSE_MS = 17'd2500;        // quick fan run, 2 to 3 s
    localparam logic [16:0] QUICK_MS     = 17'd10000;       // quick lockout pause
    localparam logic [16:0] HOLD_MS      = 17'd3000;        // long press of reset
    localparam logic [16:0] SETTLE_MS    = 17'd1;
    // ------------------------------------------------------------
    // lamp pattern in lockout, milliseconds
    // ------------------------------------------------------------
    localparam logic [16:0] LAMP_ON_MS   = 17'd10000;
    localparam logic [16:0] LAMP_DARK_MS = 17'd600;
    localparam logic [16:0] LAMP_CODE_MS = 17'd1200;
    localparam logic [16:0] BLINK_MS     = 17'd150;         // one code pulse period
    localparam logic [16:0] BLINK_ON_MS  = 17'd75;
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  REG_CTRL     = 4'h0;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam int          CTRL_RESET   = 0;
    localparam int          CTRL_LOCK    = 1;
    localparam int          ST_STATE_LSB = 0;
    localparam int          ST_CAUSE_LSB = 4;
    localparam int          ST_LOCKED    = 7;
    // ------------------------------------------------------------
    // states, gray along the normal start path
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_INIT     = 4'h0,
        ST_IDLE     = 4'h1,
        ST_WAIT_AIR = 4'h3,
        ST_PURGE    = 4'h2,
        ST_PREIGN   = 4'h6,
        ST_SAFETY   = 4'h7,
        ST_RUN      = 4'h5,
        ST_LOCKOUT  = 4'h4,
        ST_QFAN     = 4'hC,
        ST_QWAIT    = 4'hD,
        ST_RFAN     = 4'hF,
        ST_PFAN     = 4'hE,
        ST_UNDERV   = 4'hA
    } bslk_state_t;
    typedef enum logic [2:0] {
        CS_NONE        = 3'h0,
        CS_SAFETY      = 3'h1,
        CS_STRAY       = 3'h2,
        CS_AIR_CLOSED  = 3'h3,
        CS_AIR_TIMEOUT = 3'h4,
        CS_AIR_OPEN    = 3'h5,
        CS_FLAME_LOSS  = 3'h6,
        CS_MANUAL      = 3'h7
    } bslk_cause_t;
endpackage

//--- design/bslk_sequencer.sv
// burner safety lockout sequencer: phase control, lockout, lamp code
// ----------------------------------------------------------------
// Notes on behaviour
// - start only while mains above start threshold
// - mains below drop threshold in start-up, run or quick fan run forces undervoltage stop
// - undervoltage restarts itself when mains recovers
// - no flame after safety time locks out
// - flame loss while running locks out
// - air switch opening in purge/run locks out
// - closed air switch at start: fan, quick lockout
// - quick lockout ends after 10 s, retry
// - retry: still closed locks, open proceeds
// - lockout holds cause until reset request
// - stored lockout survives power, fan then relock
// - air switch 60 s timeout or reopen locks
// - end of purge: open switch or flame locks
// - thermostat open prevents burner start
// - remote terminal gives reset and lockout
// - reset held over 3 s during start-up or run forces manual lockout
// - lockout lamp lit, coded break every 11.8 s
// - reset while locked restarts start-up
// ----------------------------------------------------------------
//
// Implementation choices: the strobed register port and the register offsets.
module bslk_sequencer
    import bslk_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = bslk_pkg::TICK_CYC
)(
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     mains_above_start,
    input  wire logic                     mains_above_drop,
    input  wire logic                     thermostat_closed,
    input  wire logic                     air_flow_switch,
    input  wire logic                     flame_present,
    input  wire logic                     reset_button,
    input  wire logic                     remote_lockout_input,
    input  wire logic [2:0]               stored_cause,
    input  wire logic [bslk_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    output logic                          fan_motor,
    output logic                          ignition,
    output logic                          fuel_valve,
    output logic                          lamp,
    output logic                          alarm,
    output logic [2:0]                    nv_cause
);
    import bslk_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic             start_ok;
    logic             drop_ok;
    logic             thermo;
    logic             air;
    logic             flame;
    logic             button;
    logic [2:0]       stored;

    // two flops on every pin; only sync_b is looked at
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_a <= '0;
            sync_b <= '0;
        end
        else
        begin
            sync_a <= {stored_cause, remote_lockout_input, reset_button, flame_present,
                       air_flow_switch, thermostat_closed, mains_above_drop,
                       mains_above_start};
            sync_b <= sync_a;
        end
    end

    assign start_ok = sync_b[0];
    assign drop_ok  = sync_b[1];
    assign thermo   = sync_b[2];
    assign air      = sync_b[3];
    assign flame    = sync_b[4];
    assign button   = sync_b[5] | sync_b[6];
    assign stored   = sync_b[9:7];

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
    logic [PW-1:0] pre_cnt;
    logic          tick;

    // prescaler keeps every phase timer a plain ms count
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pre_cnt <= '0;
            tick    <= 1'b0;
        end
        else
        begin
            tick    <= (pre_cnt == PRE_LAST);
            pre_cnt <= (pre_cnt == PRE_LAST) ? '0 : pre_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // reset button and register requests
    // ------------------------------------------------------------
    logic             button_q;
    logic [MS_W-1:0]  hold_ms;
    logic             release_short;
    logic             release_long;
    logic             soft_reset;
    logic             soft_lock;

    // hold time saturates so a very long press stays long
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            button_q <= 1'b0;
            hold_ms  <= '0;
        end
        else
        begin
            button_q <= button;
            if (!button)
                hold_ms <= '0;
            else if (tick && hold_ms < HOLD_MS)
                hold_ms <= hold_ms + 1'b1;
        end
    end

    assign release_long  = button_q && !button && hold_ms >= HOLD_MS;
    assign release_short = button_q && !button && hold_ms <  HOLD_MS;
    assign soft_reset    = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_RESET];
    assign soft_lock     = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_LOCK];

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    bslk_state_t     state;
    bslk_state_t     next_state;
    bslk_cause_t     cause;
    bslk_cause_t     next_cause;
    logic [MS_W-1:0] phase_ms;
    logic            any_reset;
    logic            manual_lock;
    logic            sequencing;

    function automatic logic elapsed(input logic [MS_W-1:0] now, input logic [MS_W-1:0] lim);
        elapsed = now >= lim;
    endfunction

    assign any_reset   = release_short || release_long || soft_reset;
    assign sequencing  = state inside {ST_WAIT_AIR, ST_PURGE, ST_PREIGN, ST_SAFETY, ST_RUN};
    assign manual_lock = (release_long || soft_lock) && sequencing;

    // next state and cause
    always_comb
    begin
        next_state = state;
        next_cause = cause;
        unique case (state)
            ST_INIT:
                if (elapsed(phase_ms, SETTLE_MS))
                begin
                    next_cause = bslk_cause_t'(stored);
                    next_state = (stored != CS_NONE) ? ST_PFAN : ST_IDLE;
                end
            ST_PFAN:
                if (elapsed(phase_ms, FAN_PULSE_MS))
                    next_state = ST_LOCKOUT;
            ST_IDLE:
                if (start_ok && thermo)
                    next_state = air ? ST_QFAN : ST_WAIT_AIR;
            ST_QFAN:
                if (elapsed(phase_ms, FAN_PULSE_MS))
                    next_state = ST_QWAIT;
            ST_QWAIT:
                if (elapsed(phase_ms, QUICK_MS))
                    next_state = ST_RFAN;
            ST_RFAN:
                if (elapsed(phase_ms, FAN_PULSE_MS))
                begin
                    if (air)
                    begin
                        next_state = ST_LOCKOUT;
                        next_cause = CS_AIR_CLOSED;
                    end
                    else
                        next_state = ST_WAIT_AIR;
                end
            ST_WAIT_AIR:
                if (air)
                    next_state = ST_PURGE;
                else if (elapsed(phase_ms, AIR_WAIT_MS))
                begin
                    next_state = ST_LOCKOUT;
                    next_cause = CS_AIR_TIMEOUT;
                end
            ST_PURGE:
                if (!air)
                begin
                    next_state = ST_LOCKOUT;
                    next_cause = CS_AIR_OPEN;
                end
                else if (elapsed(phase_ms, PURGE_MS))
                begin
                    if (flame)
                    begin
                        next_state = ST_LOCKOUT;
                        next_cause = CS_STRAY;
                    end
                    else
                        next_state = ST_PREIGN;
                end
            ST_PREIGN:
                if (!air)
                begin
                    next_state = ST_LOCKOUT;
                    next_cause = CS_AIR_OPEN;
                end
                else if (elapsed(phase_ms, PREIGN_MS))
                    next_state = ST_SAFETY;
            ST_SAFETY:
                if (!air)
                begin
                    next_state = ST_LOCKOUT;
                    next_cause = CS_AIR_OPEN;
                end
                else if (elapsed(phase_ms, SAFETY_MS))
                begin
                    if (flame)
                        next_state = ST_RUN;
                    else
                    begin
                        next_state = ST_LOCKOUT;
                        next_cause = CS_SAFETY;
                    end
                end
            ST_RUN:
                if (!air)
                begin
                    next_state = ST_LOCKOUT;
                    next_cause = CS_AIR_OPEN;
                end
                else if (!flame)
                begin
                    next_state = ST_LOCKOUT;
                    next_cause = CS_FLAME_LOSS;
                end
                else if (!thermo)
                    next_state = ST_IDLE;                    // controlled shutdown
            ST_UNDERV:
                if (start_ok)
                    next_state = ST_IDLE;
            ST_LOCKOUT:
                if (any_reset)
                begin
                    next_state = ST_IDLE;
                    next_cause = CS_NONE;
                end
            default:
                next_state = ST_INIT;
        endcase
        // manual lockout outranks phase faults; undervoltage outranks both
        if (manual_lock)
        begin
            next_state = ST_LOCKOUT;
            next_cause = CS_MANUAL;
        end
        if (!drop_ok && (sequencing || state inside {ST_QFAN, ST_RFAN}))
        begin
            next_state = ST_UNDERV;
            next_cause = cause;
        end
    end

    // state, cause and phase timer
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state    <= ST_INIT;
            cause    <= CS_NONE;
            phase_ms <= '0;
        end
        else
        begin
            state <= next_state;
            cause <= next_cause;
            if (next_state != state)
                phase_ms <= '0;
            else if (tick && phase_ms < AIR_WAIT_MS)
                phase_ms <= phase_ms + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // lockout lamp pattern
    // ------------------------------------------------------------
    localparam logic [MS_W-1:0] CODE_START = LAMP_ON_MS + LAMP_DARK_MS;
    localparam logic [MS_W-1:0] LAMP_LAST  = CODE_START + LAMP_CODE_MS - 1'b1;
    logic [MS_W-1:0] lamp_ms;
    logic [MS_W-1:0] code_ms;
    logic [MS_W-1:0] blink_ms;
    logic [MS_W-1:0] code_len;
    logic            code_lit;

    // lamp cycle restarts each time lockout is entered
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            lamp_ms <= '0;
        else if (state != ST_LOCKOUT)
            lamp_ms <= '0;
        else if (tick)
            lamp_ms <= (lamp_ms == LAMP_LAST) ? '0 : lamp_ms + 1'b1;
    end

    // cause is shown as that many short pulses in the code window
    assign code_ms  = lamp_ms - CODE_START;
    assign blink_ms = code_ms % BLINK_MS;
    assign code_len = MS_W'(cause) * BLINK_MS;
    assign code_lit = lamp_ms >= CODE_START && code_ms < code_len && blink_ms < BLINK_ON_MS;

    // ------------------------------------------------------------
    // relay and indicator outputs
    // ------------------------------------------------------------
    // all loads drop in undervoltage, lockout and idle
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fan_motor  <= 1'b0;
            ignition   <= 1'b0;
            fuel_valve <= 1'b0;
            lamp       <= 1'b0;
            alarm      <= 1'b0;
            nv_cause   <= CS_NONE;
        end
        else
        begin
            fan_motor  <= sequencing || state inside {ST_QFAN, ST_RFAN, ST_PFAN};
            ignition   <= state inside {ST_PREIGN, ST_SAFETY};
            fuel_valve <= state inside {ST_SAFETY, ST_RUN};
            lamp       <= (state == ST_LOCKOUT) ? (lamp_ms < LAMP_ON_MS || code_lit)
                                                : (state == ST_RUN);
            alarm      <= (state == ST_LOCKOUT);
            nv_cause   <= cause;                            // kept by the memory outside
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // control bits are pulses, so the control word reads as zero
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= '0;
        else if (reg_rd && reg_addr == REG_STATUS)
        begin
            reg_rdata                           <= '0;
            reg_rdata[ST_STATE_LSB +: 4]        <= state;
            reg_rdata[ST_CAUSE_LSB +: 3]        <= cause;
            reg_rdata[ST_LOCKED]                <= (state == ST_LOCKOUT);
        end
        else
            reg_rdata <= '0;
    end
endmodule

//--- testbench/bslk_sequencer_monitor.sv
// port-level assertion checker for the burner lockout sequencer
module bslk_sequencer_monitor
(
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       mains_above_drop,
    input wire logic       flame_present,
    input wire logic       fan_motor,
    input wire logic       ignition,
    input wire logic       fuel_valve,
    input wire logic       lamp,
    input wire logic       alarm,
    input wire logic [2:0] nv_cause
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // relay interlocks along the start path
    // ------------------------------------------------------------
    chk_valve_with_fan:
        assert property (fuel_valve |-> fan_motor)
        else $error("fuel valve open without fan");
    chk_ign_with_fan:
        assert property (ignition |-> fan_motor)
        else $error("ignition on without fan");
    chk_valve_after_ign:
        assert property ($rose(fuel_valve) |-> ignition)
        else $error("fuel valve opened outside the ignition phase");
    // ------------------------------------------------------------
    // lockout behaviour
    // ------------------------------------------------------------
    chk_lock_relays_off:
        assert property (alarm |-> !(fan_motor || ignition || fuel_valve))
        else $error("relay on while locked out");
    chk_lock_cause_held:
        assert property (alarm && $past(alarm) |-> nv_cause != 3'h0 && $stable(nv_cause))
        else $error("lockout cause lost or changed");
    chk_lock_lamp_lit:
        assert property ($rose(alarm) |-> ##2 lamp [*8])
        else $error("lamp not lit at start of lockout");
    // ------------------------------------------------------------
    // supervision of mains and flame; slack covers the 2FF sync
    // ------------------------------------------------------------
    chk_drop_cuts_fuel:
        assert property (!mains_above_drop [*6] |-> !fuel_valve && !ignition)
        else $error("gas path still on with mains below drop level");
    chk_flame_loss_stop:
        assert property ((fuel_valve && !ignition && !flame_present) [*6] |=> !fuel_valve)
        else $error("fuel valve held after flame loss");
    cover property ($rose(alarm));
    cover property (fuel_valve && !ignition);
    cover property ($fell(mains_above_drop));
endmodule

bind bslk_sequencer bslk_sequencer_monitor u_mon (
    .ref_clk          (ref_clk),
    .sys_rst          (sys_rst),
    .mains_above_drop (mains_above_drop),
    .flame_present    (flame_present),
    .fan_motor        (fan_motor),
    .ignition         (ignition),
    .fuel_valve       (fuel_valve),
    .lamp             (lamp),
    .alarm            (alarm),
    .nv_cause         (nv_cause)
);

//--- testbench/bslk_plant.sv
// far-side model: air switch and flame detector reacting to the relays
module bslk_plant
(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic fan_motor,
    input  wire logic fuel_valve,
    input  wire logic weld,
    input  wire logic air_break,
    input  wire logic no_flame,
    output logic      air_flow_switch,
    output logic      flame_present
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] fan_age;
    logic [7:0] fuel_age;
    // ------------------------------------------------------------
    // run-up counters, cleared as soon as the relay drops
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst || !fan_motor)
            fan_age <= 8'h00;
        else if (fan_age != 8'hFF)
            fan_age <= fan_age + 8'h01;
    end
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst || !fuel_valve)
            fuel_age <= 8'h00;
        else if (fuel_age != 8'hFF)
            fuel_age <= fuel_age + 8'h01;
    end
    // switch closes only once the fan has spun up; a welded one never opens
    assign air_flow_switch = weld || (fan_age >= 8'h32 && !air_break);
    // flame builds shortly after gas flows, never without gas
    assign flame_present = !no_flame && fuel_age >= 8'h14;
endmodule

//--- testbench/bslk_sequencer_tb.sv
// self-checking bench for the burner lockout sequencer
module bslk_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bslk_pkg::*;
    logic        ref_clk, sys_rst, reg_wr, reg_rd, reset_button, remote_lockout_input;
    logic        mains_above_start, mains_above_drop, thermostat_closed, weld, air_break;
    logic        no_flame, air_flow_switch, flame_present, fan_motor, ignition, fuel_valve;
    logic        lamp, alarm;
    logic [2:0]  stored_cause, nv_cause;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, st;
    int          errors, samples_checked;
    // one tick per clock keeps the 24 s purge at 24000 cycles
    bslk_sequencer #(.TICK_CYCLES(1)) uut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .mains_above_start(mains_above_start),
        .mains_above_drop(mains_above_drop), .thermostat_closed(thermostat_closed),
        .air_flow_switch(air_flow_switch), .flame_present(flame_present),
        .reset_button(reset_button), .remote_lockout_input(remote_lockout_input),
        .stored_cause(stored_cause), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fan_motor(fan_motor),
        .ignition(ignition), .fuel_valve(fuel_valve), .lamp(lamp), .alarm(alarm),
        .nv_cause(nv_cause));
    bslk_plant u_plant (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .fan_motor(fan_motor),
        .fuel_valve(fuel_valve), .weld(weld), .air_break(air_break), .no_flame(no_flame),
        .air_flow_switch(air_flow_switch), .flame_present(flame_present));
    always #2.5 ref_clk = ~ref_clk;
    // ------------------------------------------------------------
    // shared checking and bus tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask
    // read data stands only in the cycle after the strobe
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask
    // bounded status poll, then judge
    task wait_st(input logic [3:0] s);
        int n;
        n = 0;
        st = 32'h0;
        while (st[3:0] !== s && n < 20000)
        begin
            rd(REG_STATUS, st);
            n++;
        end
        chk(32'(st[3:0]), 32'(s));
    endtask
    task stay(input logic [3:0] s, input int n);
        repeat (n) @(posedge ref_clk);
        rd(REG_STATUS, st);
        chk(32'(st[3:0]), 32'(s));
    endtask
    task pins(input logic [2:0] exp);
        @(negedge ref_clk);
        chk(32'({fan_motor, ignition, fuel_valve}), 32'(exp));
        @(posedge ref_clk);
    endtask
    // locked flag, cause, alarm on, lamp lit, fan off
    task expect_lock(input logic [2:0] c);
        wait_st(ST_LOCKOUT);
        chk(32'(st[7:4]), 32'({1'h1, c}));
        @(negedge ref_clk);
        chk(32'({alarm, lamp, fan_motor}), 32'h6);
        @(posedge ref_clk);
    endtask
    task press(input logic remote, input int n);
        if (remote) remote_lockout_input <= 1'h1; else reset_button <= 1'h1;
        repeat (n) @(posedge ref_clk);
        remote_lockout_input <= 1'h0;
        reset_button         <= 1'h0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_power;
        wait_st(ST_PFAN);
        pins(3'h4);
        expect_lock(3'h5);
        chk(32'(nv_cause), 32'h5);
        rd(4'h8, st);
        chk(st, 32'h0);
        rd(REG_CTRL, st);
        chk(st, 32'h0);
        stay(ST_LOCKOUT, 200);
        wr(REG_CTRL, 32'h1);
        wait_st(ST_IDLE);
        stay(ST_IDLE, 50);
        pins(3'h0);
    endtask
    task t_quick;
        weld              <= 1'h1;
        thermostat_closed <= 1'h1;
        wait_st(ST_QFAN);
        pins(3'h4);
        stay(ST_QFAN, 2300);
        stay(ST_QWAIT, 400);
        stay(ST_QWAIT, 9000);
        stay(ST_RFAN, 1200);
        expect_lock(3'h3);
        weld              <= 1'h0;
        thermostat_closed <= 1'h0;
        press(1'h0, 20);
        wait_st(ST_IDLE);
    endtask
    task t_run;
        thermostat_closed <= 1'h1;
        wait_st(ST_WAIT_AIR);
        wait_st(ST_PURGE);
        stay(ST_PURGE, 23000);
        wait_st(ST_PREIGN);
        pins(3'h6);
        wait_st(ST_SAFETY);
        wait_st(ST_RUN);
        @(negedge ref_clk);
        chk(32'({fan_motor, ignition, fuel_valve, lamp}), 32'hB);
        @(posedge ref_clk);
        no_flame <= 1'h1;
        expect_lock(3'h6);
        no_flame          <= 1'h0;
        thermostat_closed <= 1'h0;
        wr(REG_CTRL, 32'h1);
        wait_st(ST_IDLE);
    endtask
    task t_underv;
        thermostat_closed <= 1'h1;
        wait_st(ST_PURGE);
        mains_above_start <= 1'h0;
        stay(ST_PURGE, 20);
        mains_above_drop <= 1'h0;
        wait_st(ST_UNDERV);
        pins(3'h0);
        mains_above_drop <= 1'h1;
        stay(ST_UNDERV, 100);
        mains_above_start <= 1'h1;
        wait_st(ST_PURGE);
        press(1'h1, 3100);
        expect_lock(3'h7);
        press(1'h1, 20);
        wait_st(ST_PURGE);
        air_break <= 1'h1;
        expect_lock(3'h5);
        air_break <= 1'h0;
    endtask
    task t_noflame;
        no_flame <= 1'h1;
        press(1'h0, 20);
        wait_st(ST_SAFETY);
        pins(3'h7);
        stay(ST_SAFETY, 2800);
        expect_lock(3'h1);
        no_flame          <= 1'h0;
        thermostat_closed <= 1'h0;
        wr(REG_CTRL, 32'h1);
        wait_st(ST_IDLE);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        {ref_clk, reg_wr, reg_rd, reset_button, remote_lockout_input} = 5'h00;
        {thermostat_closed, weld, air_break, no_flame} = 4'h0;
        {sys_rst, mains_above_start, mains_above_drop} = 3'h7;
        {stored_cause, reg_addr, reg_wdata} = {3'h5, 4'h0, 32'h0};
        errors          = 0;
        samples_checked = 0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'h0;
        t_power;
        t_quick;
        t_run;
        t_underv;
        t_noflame;
        give_verdict;
    end
    // the scenarios need about 82000 cycles
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        give_verdict;
    end
endmodule
